/* File: ufp_map.svh */
`ifndef UFP_MAP_SVH
`define UFP_MAP_SVH

// Channel count and byte width of the port
`define UFP_CHANNELS 2
`define UFP_DATA_W 8

// Channel that the synchronous mode uses
`define UFP_SYNC_CH 0

// Bytes per direction buffer in each channel
`define UFP_BUF_BYTES 4096

// Internal clock period in ns
`define UFP_CLK_NS 40

// Least flag-high time after an asynchronous strobe, ns
`define UFP_GAP_NS 49

// Same time in internal clock cycles, rounded up
`define UFP_GAP_CYC ((`UFP_GAP_NS + `UFP_CLK_NS - 1) / `UFP_CLK_NS)

// Margin kept free in the write buffer for bytes in flight
`define UFP_ROOM_MARGIN 3

`endif

/* File: ufp_pkg.sv */
package ufp_pkg;

  // Port operating mode
  typedef enum logic {
    UFP_ASYNC,
    UFP_SYNC
  } ufp_mode_t;

endpackage

/* File: ufp_mem.sv */
module ufp_mem #(
  parameter int DATA_W = 8,
  parameter int DEPTH  = 4096,
  parameter int ADDR_W = $clog2(DEPTH)
) (
  // Clock
  input  wire logic              clk_in,
  // Write port
  input  wire logic              wr_en_in,
  input  wire logic [ADDR_W-1:0] wr_addr_in,
  input  wire logic [DATA_W-1:0] wr_data_in,
  // Read port
  input  wire logic [ADDR_W-1:0] rd_addr_in,
  output logic      [DATA_W-1:0] rd_data_out
);

  logic [DATA_W-1:0] store [DEPTH];

  // Depth must be a power of two for pointer wrap
  if (DEPTH != (1 << ADDR_W)) begin : g_chk
    $error("ufp_mem: DEPTH must equal 2**ADDR_W");
  end

  // Write side
  always_ff @(posedge clk_in) begin
    if (wr_en_in) begin
      store[wr_addr_in] <= wr_data_in;
    end
  end

  // Registered read, one cycle after the address
  always_ff @(posedge clk_in) begin
    rd_data_out <= store[rd_addr_in];
  end

endmodule

/* File: ufp_port.sv */
`include "ufp_map.svh"

// Contract
// - Bus carries a read or a write at any instant, never both.
// - Synchronous transfers and flag sampling happen on interface clock rising edges.
// - Synchronous mode drives a free-running, even-duty interface clock.
// - Synchronous mode runs on the first channel only.
// - Synchronous read starts with data-available driven low when bytes wait.
// - With turnaround enable low the first pending byte is driven.
// - Read strobe sampled low with more data advances to the next byte.
// - Data-available goes high once the last pending byte is consumed.
// - A byte is taken when space-available and write strobe are low.
// - Asynchronous mode transfers on strobe falling edges, on both channels.
// - Asynchronous mode drives no interface clock and ignores turnaround enable.
// - After an asynchronous read, data-available stays high a least time.
// - After an asynchronous write, space-available stays high a least time.
// - Each channel has its own 4 KB buffer per direction.
module ufp_port #(
  parameter int DEPTH   = `UFP_BUF_BYTES,
  parameter int GAP_CYC = `UFP_GAP_CYC
) (
  // Internal clock and reset
  input  wire logic                                clk_in,
  input  wire logic                                rst_in,
  // Interface clock source, twice the interface clock rate
  input  wire logic                                link_clk_in,
  // Mode select
  input  wire ufp_pkg::ufp_mode_t                  mode_in,
  // Host side, buffer toward the pins
  input  wire logic [`UFP_CHANNELS-1:0]            host_push_in,
  input  wire logic [`UFP_CHANNELS-1:0][`UFP_DATA_W-1:0] host_push_data_in,
  output logic      [`UFP_CHANNELS-1:0]            host_push_ready_out,
  // Host side, buffer from the pins
  input  wire logic [`UFP_CHANNELS-1:0]            host_pop_in,
  output logic      [`UFP_CHANNELS-1:0]            host_pop_valid_out,
  output logic      [`UFP_CHANNELS-1:0][`UFP_DATA_W-1:0] host_pop_data_out,
  output logic      [`UFP_CHANNELS-1:0]            host_data_waiting_out,
  // Pins
  output logic                                     interface_clock_out,
  input  wire logic                                oe_n_in,
  input  wire logic [`UFP_CHANNELS-1:0]            rd_n_in,
  input  wire logic [`UFP_CHANNELS-1:0]            wr_n_in,
  input  wire logic [`UFP_CHANNELS-1:0][`UFP_DATA_W-1:0] pin_data_in,
  output logic      [`UFP_CHANNELS-1:0][`UFP_DATA_W-1:0] pin_data_out,
  output logic      [`UFP_CHANNELS-1:0]            pin_data_oe_out,
  output logic      [`UFP_CHANNELS-1:0]            rx_data_available_n_out,
  output logic      [`UFP_CHANNELS-1:0]            tx_space_available_n_out
);
  import ufp_pkg::*;

  localparam int CH = `UFP_CHANNELS;
  localparam int DW = `UFP_DATA_W;
  localparam int SC = `UFP_SYNC_CH;
  localparam int AW = $clog2(DEPTH);
  localparam int GW = $clog2(GAP_CYC + 1);
  localparam logic [AW:0] DEPTH_C = (AW + 1)'(DEPTH);
  localparam logic [AW:0] ROOM_C  = (AW + 1)'(DEPTH - `UFP_ROOM_MARGIN);
  localparam logic [GW-1:0] GAP_C = GW'(GAP_CYC);

  if (DEPTH < 8 || DEPTH != (1 << AW) || GAP_CYC < 1) begin : g_chk
    $error("ufp_port: DEPTH must be a power of two >= 8, GAP_CYC >= 1");
  end

  // Internal-domain state shared with the link side
  ufp_mode_t         mode_q;
  logic              sync_on;
  logic [CH-1:0]     head_valid;
  logic [DW-1:0]     head_data [CH];
  logic [CH-1:0]     up_room;
  logic [CH-1:0]     s_take;
  logic [CH-1:0]     s_push;
  logic [DW-1:0]     a_dout [CH];
  logic [CH-1:0]     a_doe;
  logic [CH-1:0]     a_rxn;
  logic [CH-1:0]     a_txn;
  logic              i_req_s1, i_req_s2, i_req_seen, i_ack_tgl;
  logic              i_wr_s1, i_wr_s2, i_wr_seen, i_wack_tgl;
  logic [DW-1:0]     xfer_data;

  // Link-domain state
  logic              lrst_s1, lrst, lmode_s1, lsync, ifclk, rise;
  logic              l_rd_s1, l_rd, l_wr_s1, l_wr, l_oe_s1, l_oe;
  logic [DW-1:0]     l_dat_s1, l_dat;
  logic              l_req_tgl, l_pend, l_ack_s1, l_ack_s2, l_ack_seen;
  logic              l_full, l_consume;
  logic [DW-1:0]     l_byte;
  logic              l_wtgl, l_wfull, l_wack_s1, l_wack_s2, l_wack_seen, l_wacc;
  logic [DW-1:0]     l_wbyte;
  logic              l_room_s1, l_room;
  logic [DW-1:0]     l_dout;
  logic              l_doe, l_rxn, l_txn;

  // Mode register, from logic on the same clock
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      mode_q <= UFP_ASYNC;
    end else begin
      mode_q <= mode_in;
    end
  end

  assign sync_on = (mode_q == UFP_SYNC);

  // ---------------- Link domain ----------------

  // Reset and mode brought onto the link clock
  always_ff @(posedge link_clk_in) begin
    lrst_s1  <= rst_in;
    lrst     <= lrst_s1;
    lmode_s1 <= sync_on;
    lsync    <= lmode_s1;
  end

  // Interface clock: even duty, stopped low outside synchronous mode
  always_ff @(posedge link_clk_in) begin
    if (lrst || !lsync) begin
      ifclk <= 1'b0;
    end else begin
      ifclk <= ~ifclk;
    end
  end

  assign interface_clock_out = ifclk;
  assign rise = lsync & ~ifclk;

  // Pin inputs through two flops
  always_ff @(posedge link_clk_in) begin
    l_rd_s1  <= rd_n_in[SC];
    l_rd     <= l_rd_s1;
    l_wr_s1  <= wr_n_in[SC];
    l_wr     <= l_wr_s1;
    l_oe_s1  <= oe_n_in;
    l_oe     <= l_oe_s1;
    l_dat_s1 <= pin_data_in[SC];
    l_dat    <= l_dat_s1;
  end

  // Handshake returns and room level from the internal side
  always_ff @(posedge link_clk_in) begin
    l_ack_s1  <= i_ack_tgl;
    l_ack_s2  <= l_ack_s1;
    l_wack_s1 <= i_wack_tgl;
    l_wack_s2 <= l_wack_s1;
    l_room_s1 <= up_room[SC];
    l_room    <= l_room_s1;
  end

  assign l_consume = rise & l_full & ~l_rxn & ~l_rd & ~l_oe;
  assign l_wacc    = rise & ~l_txn & ~l_wr;

  // Read side: fetch one byte at a time, present it until consumed
  always_ff @(posedge link_clk_in) begin
    if (lrst) begin
      l_req_tgl  <= 1'b0;
      l_pend     <= 1'b0;
      l_ack_seen <= 1'b0;
      l_full     <= 1'b0;
      l_byte     <= '0;
    end else if (l_ack_s2 != l_ack_seen) begin
      l_ack_seen <= l_ack_s2;
      l_byte     <= xfer_data;
      l_full     <= 1'b1;
      l_pend     <= 1'b0;
    end else if (l_consume) begin
      l_full     <= 1'b0;
    end else if (lsync && !l_full && !l_pend) begin
      l_req_tgl  <= ~l_req_tgl;
      l_pend     <= 1'b1;
    end
  end

  // Write side: hold one accepted byte until the buffer takes it
  always_ff @(posedge link_clk_in) begin
    if (lrst) begin
      l_wtgl      <= 1'b0;
      l_wfull     <= 1'b0;
      l_wack_seen <= 1'b0;
      l_wbyte     <= '0;
    end else if (l_wack_s2 != l_wack_seen) begin
      l_wack_seen <= l_wack_s2;
      l_wfull     <= 1'b0;
    end else if (l_wacc) begin
      l_wbyte     <= l_dat;
      l_wfull     <= 1'b1;
      l_wtgl      <= ~l_wtgl;
    end
  end

  // Pin outputs, updated on interface clock rising edges
  always_ff @(posedge link_clk_in) begin
    if (lrst || !lsync) begin
      l_rxn  <= 1'b1;
      l_txn  <= 1'b1;
      l_doe  <= 1'b0;
      l_dout <= '0;
    end else if (rise) begin
      l_rxn  <= ~l_full | l_consume;
      l_txn  <= l_wfull | ~l_room | l_wacc;
      l_doe  <= ~l_oe & l_wr;
      l_dout <= l_byte;
    end
  end

  // ---------------- Internal domain ----------------

  // Link toggles brought onto the internal clock
  always_ff @(posedge clk_in) begin
    i_req_s1 <= l_req_tgl;
    i_req_s2 <= i_req_s1;
    i_wr_s1  <= l_wtgl;
    i_wr_s2  <= i_wr_s1;
  end

  assign s_take = CH'(sync_on & (i_req_s2 != i_req_seen) & head_valid[SC]) << SC;
  assign s_push = CH'(sync_on & (i_wr_s2 != i_wr_seen)) << SC;

  // Answer link requests; the data word is stable while the toggle travels
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      i_req_seen <= 1'b0;
      i_ack_tgl  <= 1'b0;
      i_wr_seen  <= 1'b0;
      i_wack_tgl <= 1'b0;
      xfer_data  <= '0;
    end else begin
      if (s_take[SC]) begin
        xfer_data  <= head_data[SC];
        i_req_seen <= i_req_s2;
        i_ack_tgl  <= ~i_ack_tgl;
      end
      if (s_push[SC]) begin
        i_wr_seen  <= i_wr_s2;
        i_wack_tgl <= ~i_wack_tgl;
      end
    end
  end

  // Per-channel buffers and asynchronous strobe engines
  for (genvar c = 0; c < CH; c++) begin : g_ch
    logic [AW:0]   dn_wp, dn_rp, up_wp, up_rp, dn_cnt, up_cnt;
    logic [DW-1:0] dn_rdata, up_wdata;
    logic [2:0]    rd_s, wr_s;
    logic [DW-1:0] d_s1, d_s2;
    logic          async_on, fetch, consume, acc_w, up_push, pop_valid, push_ready, waiting;
    logic [GW-1:0] rgap, wgap;

    assign async_on = (c != SC) ? ~sync_on : 1'b1;
    assign dn_cnt   = dn_wp - dn_rp;
    assign up_cnt   = up_wp - up_rp;
    assign consume  = async_on & ~sync_on & rd_s[2] & ~rd_s[1] & ~a_rxn[c];
    assign acc_w    = async_on & ~sync_on & wr_s[2] & ~wr_s[1] & ~a_txn[c];
    assign up_push  = (acc_w | s_push[c]) && (up_cnt != DEPTH_C);
    assign up_wdata = s_push[c] ? l_wbyte : d_s2;

    // Buffer toward the pins
    ufp_mem #(.DATA_W(DW), .DEPTH(DEPTH), .ADDR_W(AW)) u_dn (
      .clk_in      (clk_in),
      .wr_en_in    (host_push_in[c] && (dn_cnt != DEPTH_C)),
      .wr_addr_in  (dn_wp[AW-1:0]),
      .wr_data_in  (host_push_data_in[c]),
      .rd_addr_in  (dn_rp[AW-1:0]),
      .rd_data_out (dn_rdata)
    );

    // Buffer from the pins
    ufp_mem #(.DATA_W(DW), .DEPTH(DEPTH), .ADDR_W(AW)) u_up (
      .clk_in      (clk_in),
      .wr_en_in    (up_push),
      .wr_addr_in  (up_wp[AW-1:0]),
      .wr_data_in  (up_wdata),
      .rd_addr_in  (up_rp[AW-1:0]),
      .rd_data_out (host_pop_data_out[c])
    );

    // Strobes and data through two flops before use
    always_ff @(posedge clk_in) begin
      rd_s <= {rd_s[1:0], rd_n_in[c]};
      wr_s <= {wr_s[1:0], wr_n_in[c]};
      d_s1 <= pin_data_in[c];
      d_s2 <= d_s1;
    end

    // Host pushes and head prefetch for the pin reader
    always_ff @(posedge clk_in) begin
      if (rst_in) begin
        dn_wp         <= '0;
        dn_rp         <= '0;
        fetch         <= 1'b0;
        head_valid[c] <= 1'b0;
        head_data[c]  <= '0;
        push_ready    <= 1'b0;
      end else begin
        if (host_push_in[c] && (dn_cnt != DEPTH_C)) begin
          dn_wp <= dn_wp + 1'b1;
        end
        fetch <= 1'b0;
        if (fetch) begin
          head_data[c]  <= dn_rdata;
          head_valid[c] <= 1'b1;
        end else if (consume || s_take[c]) begin
          head_valid[c] <= 1'b0;
        end else if (!head_valid[c] && dn_cnt != '0) begin
          dn_rp <= dn_rp + 1'b1;
          fetch <= 1'b1;
        end
        push_ready <= (dn_cnt < (DEPTH_C - 1'b1));
      end
    end

    // Pin writes and host pops of the return buffer
    always_ff @(posedge clk_in) begin
      if (rst_in) begin
        up_wp      <= '0;
        up_rp      <= '0;
        pop_valid  <= 1'b0;
        waiting    <= 1'b0;
        up_room[c] <= 1'b0;
      end else begin
        if (up_push) begin
          up_wp <= up_wp + 1'b1;
        end
        pop_valid <= host_pop_in[c] && (up_cnt != '0);
        if (host_pop_in[c] && up_cnt != '0) begin
          up_rp <= up_rp + 1'b1;
        end
        waiting    <= (up_cnt > 1);
        up_room[c] <= (up_cnt < ROOM_C);
      end
    end

    // Asynchronous read flag with least high time after each strobe
    always_ff @(posedge clk_in) begin
      if (rst_in || !async_on || sync_on) begin
        a_rxn[c] <= 1'b1;
        rgap     <= '0;
      end else if (consume) begin
        a_rxn[c] <= 1'b1;
        rgap     <= GAP_C;
      end else if (rgap != '0) begin
        rgap     <= rgap - 1'b1;
      end else if (head_valid[c] && rd_s[1]) begin
        a_rxn[c] <= 1'b0;
      end
    end

    // Asynchronous write flag with least high time after each strobe
    always_ff @(posedge clk_in) begin
      if (rst_in || !async_on || sync_on) begin
        a_txn[c] <= 1'b1;
        wgap     <= '0;
      end else if (acc_w) begin
        a_txn[c] <= 1'b1;
        wgap     <= GAP_C;
      end else if (wgap != '0) begin
        wgap     <= wgap - 1'b1;
      end else if (up_room[c] && wr_s[1]) begin
        a_txn[c] <= 1'b0;
      end
    end

    // Asynchronous data drive, held while the read strobe is low
    always_ff @(posedge clk_in) begin
      if (rst_in) begin
        a_dout[c] <= '0;
        a_doe[c]  <= 1'b0;
      end else begin
        if (a_rxn[c] && rd_s[1]) begin
          a_dout[c] <= head_data[c];
        end
        a_doe[c] <= async_on & ~sync_on & ~rd_s[1] & wr_s[1];
      end
    end

    assign host_push_ready_out[c]   = push_ready;
    assign host_pop_valid_out[c]    = pop_valid;
    assign host_data_waiting_out[c] = waiting;

    // Synchronous channel takes the link-side pin registers
    if (c == SC) begin : g_mux
      assign pin_data_out[c]             = sync_on ? l_dout : a_dout[c];
      assign pin_data_oe_out[c]          = sync_on ? l_doe : a_doe[c];
      assign rx_data_available_n_out[c]  = sync_on ? l_rxn : a_rxn[c];
      assign tx_space_available_n_out[c] = sync_on ? l_txn : a_txn[c];
    end else begin : g_plain
      assign pin_data_out[c]             = a_dout[c];
      assign pin_data_oe_out[c]          = a_doe[c];
      assign rx_data_available_n_out[c]  = a_rxn[c];
      assign tx_space_available_n_out[c] = a_txn[c];
    end
  end

endmodule

/* File: ufp_port_asserts.sv */
`include "ufp_map.svh"

module ufp_port_asserts #(
  parameter int DEPTH   = 16,
  parameter int GAP_CYC = 2
) (
  // Clock and reset
  input wire logic                      clk_in,
  input wire logic                      rst_in,
  // Mode and host pop
  input wire ufp_pkg::ufp_mode_t        mode_in,
  input wire logic [`UFP_CHANNELS-1:0]  host_pop_in,
  input wire logic [`UFP_CHANNELS-1:0]  host_pop_valid_out,
  // Pins
  input wire logic                      interface_clock_out,
  input wire logic [`UFP_CHANNELS-1:0]  rd_n_in,
  input wire logic [`UFP_CHANNELS-1:0]  wr_n_in,
  input wire logic [`UFP_CHANNELS-1:0]  pin_data_oe_out,
  input wire logic [`UFP_CHANNELS-1:0]  rx_data_available_n_out,
  input wire logic [`UFP_CHANNELS-1:0]  tx_space_available_n_out
);
  timeunit 1ns;
  timeprecision 100ps;
  import ufp_pkg::*;

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (rst_in);

  // Interface clock parked in async mode
  a_async_clk_low: assert property ((mode_in == UFP_ASYNC)[*4] |-> !interface_clock_out)
    else $error("interface clock runs in async mode");
  // Second channel silent in sync mode
  a_sync_ch1_idle: assert property ((mode_in == UFP_SYNC)[*4] |->
    rx_data_available_n_out[1] && tx_space_available_n_out[1] && !pin_data_oe_out[1])
    else $error("second channel active in sync mode");
  // Turnaround input has no effect in async mode
  a_async_oe_ignored: assert property ((mode_in == UFP_ASYNC && rd_n_in[0])[*4] |->
    !pin_data_oe_out[0]) else $error("bus driven without read strobe");

  // Per channel strobe, flag and pop relations
  for (genvar c = 0; c < `UFP_CHANNELS; c++) begin : g_ch
    a_rx_gap_held: assert property (mode_in == UFP_ASYNC &&
      $rose(rx_data_available_n_out[c]) |-> rx_data_available_n_out[c][*2])
      else $error("data flag gap too short");
    a_tx_gap_held: assert property (mode_in == UFP_ASYNC &&
      $rose(tx_space_available_n_out[c]) |-> tx_space_available_n_out[c][*2])
      else $error("space flag gap too short");
    a_rd_takes_byte: assert property (mode_in == UFP_ASYNC && $fell(rd_n_in[c]) &&
      !rx_data_available_n_out[c] |-> ##[1:4] rx_data_available_n_out[c])
      else $error("read strobe did not take a byte");
    a_wr_takes_byte: assert property (mode_in == UFP_ASYNC && $fell(wr_n_in[c]) &&
      !tx_space_available_n_out[c] |-> ##[1:4] tx_space_available_n_out[c])
      else $error("write strobe did not take a byte");
    a_pop_has_cause: assert property (host_pop_valid_out[c] |-> $past(host_pop_in[c]))
      else $error("pop valid without pop");
    a_one_direction: assert property ((rd_n_in[c] && !wr_n_in[c])[*4] |->
      !pin_data_oe_out[c]) else $error("bus driven during write");
  end
endmodule

bind ufp_port ufp_port_asserts #(.DEPTH(DEPTH), .GAP_CYC(GAP_CYC)) u_ufp_port_asserts (
  .clk_in(clk_in), .rst_in(rst_in), .mode_in(mode_in), .host_pop_in(host_pop_in),
  .host_pop_valid_out(host_pop_valid_out), .interface_clock_out(interface_clock_out),
  .rd_n_in(rd_n_in), .wr_n_in(wr_n_in), .pin_data_oe_out(pin_data_oe_out),
  .rx_data_available_n_out(rx_data_available_n_out),
  .tx_space_available_n_out(tx_space_available_n_out)
);

/* File: ufp_ext.sv */
module ufp_ext (
  // Clocks
  input  wire logic            clk_in,
  input  wire logic            ifc_clk_in,
  // Device flags and bus
  input  wire logic [1:0]      rx_avail_n_in,
  input  wire logic [1:0]      tx_room_n_in,
  input  wire logic [1:0][7:0] bus_in,
  // Strobes and bus drive
  output logic      [1:0]      rd_n_out,
  output logic      [1:0]      wr_n_out,
  output logic                 oe_n_out,
  output logic      [1:0][7:0] data_out
);
  timeunit 1ns;
  timeprecision 100ps;

  logic [1:0] rx_seen, tx_seen;
  logic       rx_s0, tx_s0;

  // Flags as they stood before each edge, free of same-step races
  always @(negedge clk_in) begin
    rx_seen <= rx_avail_n_in;
    tx_seen <= tx_room_n_in;
  end
  always @(negedge ifc_clk_in) begin
    rx_s0 <= rx_avail_n_in[0];
    tx_s0 <= tx_room_n_in[0];
  end

  // Idle strobes high
  initial begin
    rd_n_out = 2'h3;
    wr_n_out = 2'h3;
    oe_n_out = 1'h1;
    data_out = {2{8'h5A}};
  end

  // Turnaround level set by the bench
  task automatic turn(input logic v);
    @(posedge clk_in);
    oe_n_out <= v;
  endtask

  // Async write; ok when the space flag rises after the strobe
  task automatic aput(input int ch, input logic [7:0] b, output logic ok);
    int n;
    n = 0;
    ok = 1'h0;
    @(posedge clk_in);
    while (tx_seen[ch] && n < 60) begin
      @(posedge clk_in);
      n++;
    end
    if (tx_seen[ch]) return;
    data_out[ch] <= b;
    wr_n_out[ch] <= 1'h0;
    repeat (4) @(posedge clk_in);
    ok = tx_seen[ch];
    wr_n_out[ch] <= 1'h1;
    repeat (2) @(posedge clk_in);
    data_out[ch] <= ~b; // Released bus shows inverse
    @(posedge clk_in);
  endtask

  // Async read, strobe held four cycles
  task automatic aget(input int ch, output logic [7:0] b, output logic ok);
    int n;
    n = 0;
    ok = 1'h0;
    b = 8'h00;
    @(posedge clk_in);
    while (rx_seen[ch] && n < 60) begin
      @(posedge clk_in);
      n++;
    end
    if (rx_seen[ch]) return;
    rd_n_out[ch] <= 1'h0;
    repeat (4) @(posedge clk_in);
    b = bus_in[ch];
    ok = rx_seen[ch];
    rd_n_out[ch] <= 1'h1;
    @(posedge clk_in);
  endtask

  // Sync read of one byte on channel 0
  task automatic sget(output logic [7:0] b, output logic ok);
    int n;
    n = 0;
    ok = 1'h0;
    b = 8'h00;
    @(posedge ifc_clk_in);
    while (rx_s0 && n < 60) begin
      @(posedge ifc_clk_in);
      n++;
    end
    if (rx_s0) return;
    oe_n_out <= 1'h0;
    repeat (3) @(posedge ifc_clk_in);
    b = bus_in[0];
    rd_n_out[0] <= 1'h0;
    n = 0;
    while (!rx_s0 && n < 30) begin
      @(posedge ifc_clk_in);
      n++;
    end
    ok = rx_s0;
    rd_n_out[0] <= 1'h1;
    oe_n_out <= 1'h1;
    @(posedge ifc_clk_in);
  endtask

  // Sync write of one byte on channel 0
  task automatic sput(input logic [7:0] b, output logic ok);
    int n;
    n = 0;
    ok = 1'h0;
    @(posedge ifc_clk_in);
    while (tx_s0 && n < 60) begin
      @(posedge ifc_clk_in);
      n++;
    end
    if (tx_s0) return;
    data_out[0] <= b;
    wr_n_out[0] <= 1'h0;
    n = 0;
    while (!tx_s0 && n < 30) begin
      @(posedge ifc_clk_in);
      n++;
    end
    ok = tx_s0;
    wr_n_out[0] <= 1'h1;
    @(posedge ifc_clk_in);
    data_out[0] <= ~b;
    @(posedge ifc_clk_in);
  endtask
endmodule

/* File: tb.sv */
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  import ufp_pkg::*;

  localparam int DEPTH = 16;

  logic            clk_in, rst_in, link_clk, ifc_clk, oe_n;
  ufp_mode_t       mode;
  logic [1:0]      push, push_rdy, pop, pop_vld, waiting, rd_n, wr_n, oe_out, rx_n, tx_n;
  logic [1:0][7:0] push_data, pop_data, pin_out, ext_data, bus;
  int              num_errors, samples_checked;

  // Clocks, link unrelated in phase
  initial begin
    clk_in = 1'h0;
    forever #20 clk_in = ~clk_in;
  end
  initial begin
    link_clk = 1'h0;
    #3.7;
    forever #7.5 link_clk = ~link_clk;
  end

  // Wire level from both drivers
  assign bus[0] = oe_out[0] ? pin_out[0] : ext_data[0];
  assign bus[1] = oe_out[1] ? pin_out[1] : ext_data[1];

  ufp_port #(.DEPTH(DEPTH)) u_ufp_port (
    .clk_in(clk_in), .rst_in(rst_in), .link_clk_in(link_clk), .mode_in(mode),
    .host_push_in(push), .host_push_data_in(push_data), .host_push_ready_out(push_rdy),
    .host_pop_in(pop), .host_pop_valid_out(pop_vld), .host_pop_data_out(pop_data),
    .host_data_waiting_out(waiting), .interface_clock_out(ifc_clk), .oe_n_in(oe_n),
    .rd_n_in(rd_n), .wr_n_in(wr_n), .pin_data_in(bus), .pin_data_out(pin_out),
    .pin_data_oe_out(oe_out), .rx_data_available_n_out(rx_n),
    .tx_space_available_n_out(tx_n)
  );

  ufp_ext u_ufp_ext (
    .clk_in(clk_in), .ifc_clk_in(ifc_clk), .rx_avail_n_in(rx_n), .tx_room_n_in(tx_n),
    .bus_in(bus), .rd_n_out(rd_n), .wr_n_out(wr_n), .oe_n_out(oe_n), .data_out(ext_data)
  );

  task automatic chk(input string name, input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
      num_errors++;
    end
  endtask

  task automatic end_of_test();
    if (num_errors == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // Host pushes n bytes from base
  task automatic push_seq(input int ch, input logic [7:0] base, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge clk_in);
      push[ch] <= 1'h1;
      push_data[ch] <= base + 8'(i);
    end
    @(posedge clk_in);
    push[ch] <= 1'h0;
  endtask

  // Host pops n bytes, then one pop on empty
  task automatic pop_seq(input int ch, input logic [7:0] base, input int n);
    for (int i = 0; i <= n; i++) begin
      @(posedge clk_in);
      pop[ch] <= 1'h1;
      @(posedge clk_in);
      pop[ch] <= 1'h0;
      #1;
      chk("pop valid", 8'(pop_vld[ch]), 8'(i < n));
      if (i < n) chk("pop data", pop_data[ch], base + 8'(i));
    end
  endtask

  task automatic t_reset();
    #1;
    chk("reset flags", {4'h0, rx_n, tx_n}, 8'h0F);
    chk("reset drive", {2'h0, oe_out, pop_vld, push_rdy}, 8'h00);
    chk("reset clock", 8'(ifc_clk), 8'h00);
  endtask

  // Both channels read and written, kept apart
  task automatic t_async();
    logic [7:0] b;
    logic       ok;
    for (int c = 0; c < 2; c++) begin
      push_seq(c, 8'h10 + 8'(c * 16), 3);
      for (int i = 0; i < 3; i++) begin
        u_ufp_ext.aget(c, b, ok);
        chk("async read taken", 8'(ok), 8'h01);
        chk("async read data", b, 8'h10 + 8'(c * 16 + i));
      end
      repeat (8) @(posedge clk_in);
      chk("async rx idle", 8'(rx_n[c]), 8'h01);
    end
    for (int c = 0; c < 2; c++)
      for (int i = 0; i < 3; i++) begin
        u_ufp_ext.aput(c, 8'h40 + 8'(c * 16 + i), ok);
        chk("async write taken", 8'(ok), 8'h01);
      end
    repeat (4) @(posedge clk_in);
    #1;
    chk("data waiting", {6'h00, waiting}, 8'h03);
    chk("push ready", {6'h00, push_rdy}, 8'h03);
    for (int c = 0; c < 2; c++)
      pop_seq(c, 8'h40 + 8'(c * 16), 3);
    chk("none waiting", {6'h00, waiting}, 8'h00);
  endtask

  // Fill until refused, then drain
  task automatic t_fill();
    logic ok;
    for (int i = 0; i <= DEPTH - 3; i++) begin
      u_ufp_ext.aput(0, 8'h80 + 8'(i), ok);
      chk("fill accept", 8'(ok), 8'(i < DEPTH - 3));
    end
    pop_seq(0, 8'h80, DEPTH - 3);
    repeat (6) @(posedge clk_in);
    chk("room again", 8'(tx_n[0]), 8'h00);
  endtask

  // Turnaround low in async mode changes nothing
  task automatic t_turn();
    logic [7:0] b;
    logic       ok;
    push_seq(0, 8'hC5, 1);
    u_ufp_ext.turn(1'h0);
    repeat (8) @(posedge clk_in);
    chk("async oe ignored", 8'(oe_out[0]), 8'h00);
    chk("async no clock", 8'(ifc_clk), 8'h00);
    u_ufp_ext.turn(1'h1);
    u_ufp_ext.aget(0, b, ok);
    chk("turn data", b, 8'hC5);
  endtask

  // Sync mode on channel 0
  task automatic t_sync();
    logic [7:0] b;
    logic       ok;
    realtime    t0, t1, t2;
    @(posedge clk_in);
    mode <= UFP_SYNC;
    repeat (10) @(posedge clk_in);
    @(posedge ifc_clk);
    t0 = $realtime;
    @(negedge ifc_clk);
    t1 = $realtime;
    @(posedge ifc_clk);
    t2 = $realtime;
    chk("clock period", 8'(int'(t2 - t0)), 8'h1E);
    chk("clock high", 8'(int'(t1 - t0)), 8'h0F);
    chk("ch1 idle", {6'h00, rx_n[1], tx_n[1]}, 8'h03);
    push_seq(0, 8'hE0, 3);
    for (int i = 0; i < 3; i++) begin
      u_ufp_ext.sget(b, ok);
      chk("sync read taken", 8'(ok), 8'h01);
      chk("sync read data", b, 8'hE0 + 8'(i));
    end
    repeat (10) @(posedge clk_in);
    chk("sync rx idle", 8'(rx_n[0]), 8'h01);
    for (int i = 0; i < 3; i++) begin
      u_ufp_ext.sput(8'hF0 + 8'(i), ok);
      chk("sync write taken", 8'(ok), 8'h01);
    end
    repeat (10) @(posedge clk_in);
    pop_seq(0, 8'hF0, 3);
  endtask

  // Main sequence
  initial begin
    num_errors = 0;
    samples_checked = 0;
    rst_in = 1'h1;
    mode = UFP_ASYNC;
    push = 2'h0;
    pop = 2'h0;
    push_data = '0;
    repeat (5) @(posedge clk_in);
    t_reset();
    @(posedge clk_in);
    rst_in <= 1'h0;
    t_async();
    t_fill();
    t_turn();
    t_sync();
    end_of_test();
  end

  // Watchdog
  initial begin
    repeat (20000) @(posedge clk_in);
    num_errors++;
    end_of_test();
  end
endmodule
